// ==== spe_pkg.sv ====
package spe_pkg;

  // opcodes, shifted msb first
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;

  // status byte bit positions
  localparam int ST_LOCK = 7;
  localparam int ST_BP_HIGH = 3;
  localparam int ST_BP_LOW = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;

  // nonvolatile status {lock, bp_high, bp_low} after reset
  localparam logic [2:0] NV_RESET = 3'h0;
  localparam logic [31:0] WORD_ERASED = 32'hFFFFFFFF;

  // rising-edge counts at which header phases end
  localparam logic [4:0] LAST_OPCODE_BIT = 5'h07;
  localparam logic [4:0] LAST_STATUS_BIT = 5'h0F;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h17;

  localparam int ADDR_W = 15;
  localparam int WORD_AW = 13;
  localparam int NWORDS = 8192;
  localparam int ECC_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_WORDS = 16;
  localparam int TIMER_W = 18;

  // programming time
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    S_OPCODE = 3'b000,
    S_ADDR = 3'b001,
    S_RDATA = 3'b010,
    S_WDATA = 3'b011,
    S_STATUS_OUT = 3'b100,
    S_STATUS_IN = 3'b101,
    S_DONE = 3'b110,
    S_IGNORE = 3'b111
  } spe_state_t;

  // hamming position of data bit i, skipping powers of two
  function automatic logic [5:0] spe_pos(input int i);
    int k;
    logic [5:0] r;
    k = 0;
    r = '0;
    for (int p = 3; p < 64; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (k == i) r = 6'(p);
        k++;
      end
    end
    return r;
  endfunction

  function automatic logic [ECC_W-1:0] spe_ecc(input logic [31:0] d);
    logic [ECC_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) acc = acc ^ spe_pos(i);
    end
    return acc;
  endfunction

  // single-bit correction; a flipped check bit leaves data alone
  function automatic logic [31:0] spe_fix(input logic [31:0] d,
                                          input logic [ECC_W-1:0] c);
    logic [ECC_W-1:0] s;
    logic [31:0] r;
    s = spe_ecc(d) ^ c;
    r = d;
    for (int i = 0; i < 32; i++) begin
      if (s == spe_pos(i)) r[i] = ~d[i];
    end
    return r;
  endfunction

  function automatic logic spe_known(input logic [7:0] op);
    return op == OP_WRITE_ENABLE || op == OP_WRITE_DISABLE ||
           op == OP_STATUS_READ || op == OP_STATUS_WRITE ||
           op == OP_MEM_READ || op == OP_MEM_WRITE;
  endfunction

  localparam logic [ECC_W-1:0] ECC_ERASED = spe_ecc(WORD_ERASED);

endpackage

// ==== spe_buf2.sv ====
`timescale 1ns/1ps
module spe_buf2 #(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DW-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DW-1:0] out_data
);
  logic [DW-1:0] slot [2];
  logic wp;
  logic rp;
  logic [1:0] count;
  logic next_wp;
  logic next_rp;
  logic [1:0] next_count;
  logic do_push;
  logic do_pop;

  assign in_ready = count != 2'h2;
  assign out_valid = count != 2'h0;
  assign out_data = slot[rp];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    next_wp = wp ^ do_push;
    next_rp = rp ^ do_pop;
    next_count = count + {1'b0, do_push} - {1'b0, do_pop};
    if (clr) begin
      next_wp = 1'b0;
      next_rp = 1'b0;
      next_count = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp <= 1'b0;
      rp <= 1'b0;
      count <= 2'h0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push && !clr) slot[wp] <= in_data;
  end
endmodule

// ==== spe_core.sv ====
`timescale 1ns/1ps
module spe_core
  import spe_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic standby
);
  // pin synchronisers; pin_m feeds only pin_s
  logic [4:0] pin_m, pin_s;
  logic cs_s, cs_d, sck_s, sck_d, si_s, hold_s, wp_s;
  assign {cs_s, sck_s, si_s, hold_s, wp_s} = pin_s;

  // reset levels match idle pins: select, pause and guard high
  always_ff @(posedge clk) begin
    pin_m <= rst_n ? {cs_n, sck, si, hold_n, wp_n} : 5'h13;
    pin_s <= rst_n ? pin_m : 5'h13;
    cs_d <= rst_n ? cs_s : 1'b1;
    sck_d <= rst_n ? sck_s : 1'b0;
  end

  // edges counted only while selected, so idle level is irrelevant
  logic active, rise, fall, cs_rise;
  assign active = !cs_s && hold_s;
  assign rise = active && sck_s && !sck_d;
  assign fall = active && !sck_s && sck_d;
  assign cs_rise = cs_s && !cs_d;

  spe_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, opcode, next_opcode, oshift, next_oshift;
  logic [2:0] bitpos, next_bitpos;
  logic [ADDR_W-1:0] addr, next_addr, rd_addr, next_rd_addr;
  logic [5:0] pcol, next_pcol;
  logic [63:0] pmask, next_pmask;
  logic next_so, next_so_oe, next_standby, fill, next_fill, talk, next_talk;
  logic write_enable_latch, next_wel, busy, next_busy, kind_mem, next_kind_mem;
  logic [2:0] nv, next_nv, nv_new, next_nv_new;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [4:0] sweep, next_sweep;
  logic pb_we;
  logic [7:0] in_byte, status_byte, rd_byte;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [31:0] mem [NWORDS];
  logic [ECC_W-1:0] emem [NWORDS];
  logic [31:0] rd_word, old_word, merged;
  logic [WORD_AW-1:0] sw_idx;
  logic sweep_we;
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic [7:0] buf_out;

  assign in_byte = {sh[6:0], si_s};
  assign status_byte = {nv[2], 3'h0, nv[1], nv[0], write_enable_latch, busy};
  assign rd_word = spe_fix(mem[rd_addr[ADDR_W-1:2]],
                           emem[rd_addr[ADDR_W-1:2]]);
  assign rd_byte = rd_word[8*rd_addr[1:0] +: 8];
  assign sw_idx = {addr[ADDR_W-1:6], sweep[3:0]};
  assign old_word = spe_fix(mem[sw_idx], emem[sw_idx]);
  assign sweep_we = busy && kind_mem && !sweep[4];
  assign buf_pop = fall && state == S_RDATA && bitpos == 3'h0;

  // untouched bytes keep their corrected old value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[8*b +: 8] = pmask[{sweep[3:0], 2'(b)}] ?
                         pbuf[{sweep[3:0], 2'(b)}] : old_word[8*b +: 8];
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_opcode = opcode;
    next_oshift = oshift;
    next_bitpos = bitpos;
    next_addr = addr;
    next_rd_addr = rd_addr;
    next_pcol = pcol;
    next_pmask = pmask;
    next_so = so;
    next_so_oe = so_oe;
    next_fill = fill;
    next_talk = talk;
    next_wel = write_enable_latch;
    next_busy = busy;
    next_kind_mem = kind_mem;
    next_nv = nv;
    next_nv_new = nv_new;
    next_timer = timer;
    next_sweep = sweep;
    pb_we = 1'b0;
    if (busy) begin
      next_timer = timer + 1'b1;
      if (!sweep[4]) next_sweep = sweep + 1'b1;
      if (timer == TIMER_W'(PROG_CYC - 1)) begin
        next_busy = 1'b0;
        next_wel = 1'b0;
        if (!kind_mem) next_nv = nv_new;
      end
    end
    if (fill && buf_in_ready) next_rd_addr = rd_addr + 1'b1;
    if (cs_s) begin
      // a command only ever begins after a select falling edge
      next_state = S_OPCODE;
      next_cnt = 5'h00;
      next_bitpos = 3'h0;
      next_so_oe = 1'b0;
      next_fill = 1'b0;
      next_talk = 1'b0;
      if (cs_rise && state == S_DONE) begin
        if (opcode == OP_WRITE_ENABLE) next_wel = 1'b1;
        if (opcode == OP_WRITE_DISABLE) next_wel = 1'b0;
        if (opcode == OP_STATUS_WRITE && write_enable_latch &&
            !(nv[2] && !wp_s)) begin
          next_busy = 1'b1;
          next_kind_mem = 1'b0;
          next_timer = '0;
        end
      end
      // programming starts on select rise at a byte boundary
      if (cs_rise && state == S_WDATA && bitpos == 3'h0 &&
          pmask != 64'h0 && write_enable_latch) begin
        next_busy = 1'b1;
        next_kind_mem = 1'b1;
        next_timer = '0;
        next_sweep = 5'h00;
      end
    end else if (!hold_s) begin
      next_so_oe = 1'b0;
    end else begin
      // output comes back by itself once a pause ends
      if (talk) next_so_oe = 1'b1;
      if (fall && (state == S_STATUS_OUT || state == S_RDATA)) begin
        next_so_oe = 1'b1;
        next_talk = 1'b1;
        next_bitpos = bitpos + 1'b1;
        if (bitpos == 3'h0) begin
          // status refetched each byte so busy and latch stay live
          next_so = (state == S_STATUS_OUT) ? status_byte[7]
                                            : buf_out[7];
          next_oshift = (state == S_STATUS_OUT) ? {status_byte[6:0], 1'b0}
                                                : {buf_out[6:0], 1'b0};
        end else begin
          next_so = oshift[7];
          next_oshift = {oshift[6:0], 1'b0};
        end
      end
      if (rise) begin
        next_sh = in_byte;
        unique case (state)
          S_OPCODE: begin
            next_cnt = cnt + 1'b1;
            if (cnt == LAST_OPCODE_BIT) begin
              next_opcode = in_byte;
              if (busy && in_byte != OP_STATUS_READ) begin
                next_state = S_IGNORE;
              end else if (!spe_known(in_byte)) begin
                next_state = S_IGNORE;
              end else if (in_byte == OP_STATUS_READ) begin
                next_state = S_STATUS_OUT;
              end else if (in_byte == OP_STATUS_WRITE) begin
                next_state = S_STATUS_IN;
              end else if (in_byte == OP_MEM_READ ||
                           in_byte == OP_MEM_WRITE) begin
                next_state = S_ADDR;
              end else begin
                next_state = S_DONE;
              end
            end
          end
          S_ADDR: begin
            next_cnt = cnt + 1'b1;
            // 16 bits shifted into 15 drops the top one
            next_addr = {addr[ADDR_W-2:0], si_s};
            if (cnt == LAST_ADDR_BIT) begin
              if (opcode == OP_MEM_READ) begin
                next_state = S_RDATA;
                next_rd_addr = {addr[ADDR_W-2:0], si_s};
                next_fill = 1'b1;
              end else begin
                next_state = S_WDATA;
                next_pcol = {addr[4:0], si_s};
                next_pmask = 64'h0;
              end
            end
          end
          S_WDATA: begin
            next_bitpos = bitpos + 1'b1;
            if (bitpos == 3'h7) begin
              // beyond 64 bytes the column wraps inside the page
              pb_we = 1'b1;
              next_pmask = pmask | (64'h1 << pcol);
              next_pcol = pcol + 1'b1;
            end
          end
          S_STATUS_IN: begin
            next_cnt = cnt + 1'b1;
            if (cnt == LAST_STATUS_BIT) begin
              next_nv_new = {sh[6], sh[2], sh[1]};
              next_state = S_DONE;
            end
          end
          S_DONE: next_state = S_IGNORE;
          S_RDATA, S_STATUS_OUT, S_IGNORE: next_state = state;
        endcase
      end
    end
    next_standby = cs_s && !next_busy;
  end

  always_ff @(posedge clk) begin
    state <= rst_n ? next_state : S_OPCODE;
    cnt <= rst_n ? next_cnt : 5'h00;
    sh <= rst_n ? next_sh : 8'h00;
    opcode <= rst_n ? next_opcode : 8'h00;
    oshift <= rst_n ? next_oshift : 8'h00;
    bitpos <= rst_n ? next_bitpos : 3'h0;
    addr <= rst_n ? next_addr : '0;
    rd_addr <= rst_n ? next_rd_addr : '0;
    pcol <= rst_n ? next_pcol : 6'h00;
    pmask <= rst_n ? next_pmask : 64'h0;
    so <= rst_n ? next_so : 1'b0;
    so_oe <= rst_n ? next_so_oe : 1'b0;
    standby <= rst_n ? next_standby : 1'b1;
    fill <= rst_n ? next_fill : 1'b0;
    talk <= rst_n ? next_talk : 1'b0;
    write_enable_latch <= rst_n ? next_wel : 1'b0;
    busy <= rst_n ? next_busy : 1'b0;
    kind_mem <= rst_n ? next_kind_mem : 1'b0;
    nv <= rst_n ? next_nv : NV_RESET;
    nv_new <= rst_n ? next_nv_new : NV_RESET;
    timer <= rst_n ? next_timer : '0;
    sweep <= rst_n ? next_sweep : 5'h10;
  end

  // arrays written directly: a full next copy would double storage
  always_ff @(posedge clk) begin
    if (pb_we) pbuf[pcol] <= in_byte;
    if (!rst_n) begin
      for (int w = 0; w < NWORDS; w++) begin
        mem[w] <= WORD_ERASED;
        emem[w] <= ECC_ERASED;
      end
    end else if (sweep_we) begin
      mem[sw_idx] <= merged;
      emem[sw_idx] <= spe_ecc(merged);
    end
  end

  spe_buf2 #(.DW(8)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .clr(cs_s),
    .in_valid(fill),
    .in_ready(buf_in_ready),
    .in_data(rd_byte),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out)
  );

  sequence opcode_in_s;
    rise && state == S_OPCODE && cnt == LAST_OPCODE_BIT;
  endsequence
  sequence prog_end_s;
    busy && timer == TIMER_W'(PROG_CYC - 1);
  endsequence

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  cs_hiz_a: assert property (cs_s |=> !so_oe)
    else $error("output driven while deselected");
  standby_idle_a: assert property (cs_s ##1 cs_s && !busy |-> standby)
    else $error("standby missing while idle");
  hold_hiz_a: assert property (!cs_s && !hold_s |=> !so_oe)
    else $error("output driven during pause");
  hold_back_a: assert property (!cs_s && hold_s && talk |=> so_oe)
    else $error("output not restored after pause");
  so_fall_a: assert property ($changed(so) |-> $past(fall))
    else $error("output changed without falling edge");
  sample_rise_a: assert property ($changed(sh) |-> $past(rise))
    else $error("input shifted without rising edge");
  bad_op_a: assert property (opcode_in_s and
    !spe_known(in_byte) |=> state == S_IGNORE)
    else $error("unknown opcode not ignored");
  busy_op_a: assert property (opcode_in_s and busy &&
    in_byte != OP_STATUS_READ |=> state == S_IGNORE)
    else $error("opcode taken while programming");
  wel_guard_a: assert property ($rose(busy) |-> $past(write_enable_latch))
    else $error("programming started without latch");
  busy_end_a: assert property (prog_end_s |=> !busy && !write_enable_latch)
    else $error("programming cycle end wrong");
  busy_len_a: assert property ($fell(busy) |->
    $past(timer) == TIMER_W'(PROG_CYC - 1))
    else $error("programming cycle length wrong");
  new_cmd_a: assert property (cs_s |=> state == S_OPCODE && cnt == 5'h00)
    else $error("command state not cleared by deselect");
endmodule

// ==== spe_host.sv ====
`timescale 1ns/1ps
module spe_host (
  input wire logic clk,
  input wire logic sd,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_cnt
);
  logic [7:0] last;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    rx_byte = 8'h00;
    rx_cnt = 8'h00;
    last = 8'h00;
  end

  // low phase kept long so the synced output has settled before sampling
  task automatic xfer(input logic [7:0] tx[$], input int hdr,
                      input logic cpol, input int hold_at);
    @(negedge clk);
    sck <= cpol;
    repeat (2) @(negedge clk);
    cs_n <= 1'b0;
    foreach (tx[k]) begin
      for (int b = 7; b >= 0; b--) begin
        sck <= 1'b0;
        si <= tx[k][b];
        repeat (2) @(negedge clk);
        if (k == hold_at && b == 4) begin
          hold_n <= 1'b0;
          repeat (4) begin
            repeat (2) @(negedge clk);
            sck <= ~sck;
            si <= ~si;
          end
          repeat (2) @(negedge clk);
          hold_n <= 1'b1;
          repeat (6) @(negedge clk);
        end
        repeat (4) @(negedge clk);
        last[b] = sd;
        sck <= 1'b1;
        repeat (2) @(negedge clk);
      end
      if (k >= hdr) begin
        rx_byte <= last;
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
    sck <= cpol;
    repeat (2) @(negedge clk);
    cs_n <= 1'b1;
    // released line: inverse of last value, so stale data never matches
    si <= ~si;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ==== test_spe_core.sv ====
`timescale 1ns/1ps
module test_spe_core
  import spe_pkg::*;
;
  localparam int PCYC = 800;
  logic clk, rst_n, wp_n, so, so_oe, standby, so_wire;
  logic cs_n, sck, si, hold_n;
  logic [7:0] rx_byte, rx_cnt, rx_seen;
  logic [7:0] d[3];
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [31:0] seed;
  int errors, n_checks, cyc, oe_cnt, oe0, desel_c, hold_c;

  spe_core #(.PROG_CYC(PCYC)) dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
    .so_oe(so_oe), .standby(standby));

  spe_host host (.clk(clk), .sd(so_wire), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .rx_byte(rx_byte), .rx_cnt(rx_cnt));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // undriven output flips every cycle, so a missing drive reads wrong
  always @(negedge clk) so_wire <= so_oe ? so : (so_wire === 1'b0);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (exp_q.size() != 0) errors++;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (so_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    desel_c <= cs_n ? desel_c + 1 : 0;
    hold_c <= hold_n ? 0 : hold_c + 1;
    if (desel_c > 5 && rst_n) cmp_bit(so_oe, 1'b0);
    if (hold_c > 5) cmp_bit(so_oe, 1'b0);
    if (rx_cnt != rx_seen) begin
      rx_seen <= rx_cnt;
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        cmp_byte(rx_byte & e[15:8], e[7:0] & e[15:8]);
      end else begin
        errors++;
        $display("BAD %0t got %h exp %h", $time, rx_byte, 8'h00);
      end
    end
    if (cyc > 40000) begin
      errors++;
      print_verdict;
    end
  end

  task automatic want(input logic [7:0] v, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, v});
  endtask

  task automatic go(input logic [7:0] tx[$], input int hdr = 99,
                    input logic cpol = 1'b0, input int hold_at = -1);
    host.xfer(tx, hdr, cpol, hold_at);
  endtask

  // two copies also prove the status byte repeats
  task automatic status_read_command(input logic [7:0] v, input logic [7:0] m = 8'hFF);
    want(v, m);
    want(v, m);
    go('{OP_STATUS_READ, 8'h00, 8'h00}, 1);
  endtask

  task automatic poll;
    int i;
    i = 0;
    do begin
      go('{OP_STATUS_READ, 8'h00});
      i++;
    end while (host.last[ST_BUSY] !== 1'b0 && i < 20);
    cmp_bit(host.last[ST_BUSY], 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    errors = 0;
    n_checks = 0;
    rx_seen = 8'h00;
    seed = 32'h80A7;
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    repeat (6) @(negedge clk);
    cmp_bit(standby, 1'b1);
    status_read_command(8'h00);
    for (int i = 0; i < 3; i++) want(8'hFF);
    go('{OP_MEM_READ, 8'hC1, 8'h23, 8'h00, 8'h00, 8'h00}, 3, 1'b1);
    $display("delivered state done");
    go('{OP_MEM_WRITE, 8'h00, 8'h10, 8'h55});
    status_read_command(8'h00);
    go('{OP_WRITE_ENABLE, 8'h00});
    status_read_command(8'h00);
    go('{OP_WRITE_ENABLE});
    status_read_command(8'h02);
    go('{OP_WRITE_DISABLE});
    status_read_command(8'h00);
    oe0 = oe_cnt;
    go('{8'hA5, 8'h00, 8'h00});
    cmp_bit(oe_cnt == oe0, 1'b1);
    $display("command decode done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      d[i] = seed[7:0];
    end
    go('{OP_WRITE_ENABLE});
    go('{OP_MEM_WRITE, 8'h80, 8'h3F, d[0], d[1], d[2]});
    status_read_command(8'h03);
    cmp_bit(standby, 1'b0);
    oe0 = oe_cnt;
    go('{OP_MEM_READ, 8'h00, 8'h00, 8'h00});
    cmp_bit(oe_cnt == oe0, 1'b1);
    poll;
    status_read_command(8'h00);
    cmp_bit(standby, 1'b1);
    want(d[1]);
    want(d[2]);
    want(8'hFF);
    want(8'hFF);
    go('{OP_MEM_READ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
    want(8'hFF);
    want(d[0]);
    go('{OP_MEM_READ, 8'h00, 8'h3E, 8'h00, 8'h00}, 3, 1'b0, 4);
    go('{OP_WRITE_ENABLE});
    go('{OP_MEM_WRITE, 8'h01, 8'h04, d[2], d[0], d[1], 8'h3C});
    poll;
    want(d[2]);
    want(d[0]);
    want(d[1]);
    want(8'h3C);
    go('{OP_MEM_READ, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
    $display("page write done");
    go('{OP_WRITE_ENABLE});
    go('{OP_STATUS_WRITE, 8'h8C});
    poll;
    status_read_command(8'h8C);
    wp_n <= 1'b0;
    go('{OP_WRITE_ENABLE});
    go('{OP_STATUS_WRITE, 8'h00});
    poll;
    status_read_command(8'h8C, 8'h8D);
    wp_n <= 1'b1;
    $display("status write done");
    print_verdict;
  end
endmodule
